// ---- shared/sdq_pkg.sv ----
// Package with command codes, states and timing constants for the SDRAM sequencer
package sdq_pkg;
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned PWRUP_US       = 100;
  localparam int unsigned PWRUP_CYC      = PWRUP_US * CLK_MHZ;
  localparam int unsigned TWR_NS         = 15;
  localparam int unsigned CLK_PERIOD_NS  = 1000 / CLK_MHZ;
  localparam int unsigned TWR_CYC_RAW    = (TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TWR_CYC        = (TWR_CYC_RAW < 1) ? 1 : TWR_CYC_RAW;
  localparam int unsigned TRFC_CYC       = 3;
  localparam int unsigned TMRD_CYC       = 2;
  localparam int unsigned TRAS_CYC       = 2;
  localparam int unsigned TRP_CYC        = 1;
  localparam int unsigned TREF_CYC       = 1562;
  localparam int unsigned INIT_REFS      = 2;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned BANKS          = 4;

  // Command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_INHIBIT = 4'h8;
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_ACT     = 4'h3;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [3:0] CMD_READ    = 4'h5;
  localparam logic [3:0] CMD_PRE     = 4'h2;
  localparam logic [3:0] CMD_REF     = 4'h1;
  localparam logic [3:0] CMD_LMR     = 4'h0;

  localparam logic [1:0] OP_ACT      = 2'h0;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [1:0] OP_PRE      = 2'h2;
  localparam logic [1:0] OP_READ     = 2'h3;

  typedef enum logic [3:0] {
    SDQ_PWRUP, SDQ_INIT_REF, SDQ_INIT_WAIT, SDQ_LMR, SDQ_LMR_WAIT,
    SDQ_IDLE, SDQ_REF, SDQ_REF_WAIT, SDQ_HOLD
  } sdq_state_e;
endpackage

// ---- shared/sdq_tmr_if.sv ----
// Interface carrying a countdown load and expiry between sequencer and timer
`timescale 1ns/1ns
interface sdq_tmr_if;
  logic                      load;
  logic [sdq_pkg::CNT_W-1:0] value;
  logic                      done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface

// ---- src/sdq_ctrl.sv ----
// SDRAM command sequencer: power-up, refresh scheduling and bank timing
// Function
// - Wait power-up pause, stay not ready until initialization finishes.
// - Issue two auto refresh commands after the pause.
// - Repeat two wake-up refreshes when the refresh interval was overrun.
// - Clock frequency changes only while stopped, powered down or self refreshing.
// - Only NOP or inhibit during refresh cycle time.
// - At least one NOP inside mode register set delay.
// - Wait write recovery after last write data before precharge.
// - Auto precharge write recovery holds at least one full clock.
// - Continuous page write end honours write recovery before precharge.
// - Precharge waits minimum row active time since activation.
// - One refresh per command; refreshes may be spread out.
// - Keep refreshing during power-down, leaving it as needed.
`timescale 1ns/1ns
module sdq_ctrl #(
  parameter int unsigned PWRUP_CYCLES = sdq_pkg::PWRUP_CYC,
  parameter int unsigned TREF_CYCLES  = sdq_pkg::TREF_CYC,
  parameter int unsigned ADDR_W       = 13
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              req_valid,
  input  wire logic [1:0]        req_op,
  input  wire logic [1:0]        req_bank,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic              req_auto_pre,
  input  wire logic              pd_req,
  output logic                   req_ready,
  output logic                   init_done,
  output logic                   clk_change_ok,
  output logic                   mem_cke,
  output logic                   mem_cs_n,
  output logic                   mem_ras_n,
  output logic                   mem_cas_n,
  output logic                   mem_we_n,
  output logic [1:0]             mem_ba,
  output logic [ADDR_W-1:0]      mem_addr
);
  localparam int unsigned TW = sdq_pkg::CNT_W;

  initial begin
    if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= (1 << TW)) $error("PWRUP_CYCLES out of range");
    if (TREF_CYCLES < 1 || TREF_CYCLES >= (1 << TW)) $error("TREF_CYCLES out of range");
    if (ADDR_W < 11) $error("ADDR_W too small");
  end

  function automatic logic [TW-1:0] cyc(input int unsigned n);
    cyc = TW'(n);
  endfunction

  sdq_tmr_if tif ();
  sdq_timer i_sdq_timer (.clk(clk), .sys_rst(sys_rst), .tif(tif));

  sdq_pkg::sdq_state_e st_ff, nxt_st;
  logic [1:0]          refs_ff, nxt_refs;
  logic [TW-1:0]       refcnt_ff;
  logic                ref_due_ff;
  logic                overrun_ff;
  logic                init_ff;
  logic [3:0]          cmd_ff, nxt_cmd;
  logic [1:0]          ba_ff, nxt_ba;
  logic [ADDR_W-1:0]   addr_ff, nxt_addr;
  logic                ready_ff;
  logic                cke_ff;
  logic [3:0]          ras_ff [sdq_pkg::BANKS];
  logic [3:0]          wr_ff  [sdq_pkg::BANKS];
  logic                tld;
  logic [TW-1:0]       tval;
  logic                pwr_ld_ff;

  assign tif.load  = tld;
  assign tif.value = tval;

  wire in_idle  = (st_ff == sdq_pkg::SDQ_IDLE);
  wire sel_pre  = (req_op == sdq_pkg::OP_PRE);
  wire sel_act  = (req_op == sdq_pkg::OP_ACT);
  wire sel_wr   = (req_op == sdq_pkg::OP_WRITE);
  wire pre_ok   = (ras_ff[req_bank] == '0) && (wr_ff[req_bank] == '0);
  wire accept   = in_idle && req_valid && !ref_due_ff && cke_ff && (!sel_pre || pre_ok);
  wire ref_tick = (refcnt_ff == '0);

  always_comb begin
    nxt_st   = st_ff;
    nxt_refs = refs_ff;
    nxt_cmd  = sdq_pkg::CMD_NOP;
    nxt_ba   = ba_ff;
    nxt_addr = addr_ff;
    tld      = 1'b0;
    tval     = '0;
    unique case (st_ff)
      sdq_pkg::SDQ_PWRUP: begin
        nxt_cmd = sdq_pkg::CMD_INHIBIT;
        // Pause loaded once on reset release; done stays low during the load
        tld     = pwr_ld_ff;
        tval    = cyc(PWRUP_CYCLES);
        if (tif.done) begin
          nxt_st   = sdq_pkg::SDQ_INIT_REF;
          nxt_refs = '0;
        end
      end
      sdq_pkg::SDQ_INIT_REF: begin
        nxt_cmd  = sdq_pkg::CMD_REF;
        nxt_refs = refs_ff + 2'h1;
        tld      = 1'b1;
        tval     = cyc(sdq_pkg::TRFC_CYC - 1);
        nxt_st   = sdq_pkg::SDQ_INIT_WAIT;
      end
      sdq_pkg::SDQ_INIT_WAIT: begin
        if (tif.done) begin
          if (refs_ff == 2'(sdq_pkg::INIT_REFS)) begin
            nxt_st = init_ff ? sdq_pkg::SDQ_IDLE : sdq_pkg::SDQ_LMR;
          end else begin
            nxt_st = sdq_pkg::SDQ_INIT_REF;
          end
        end
      end
      sdq_pkg::SDQ_LMR: begin
        nxt_cmd  = sdq_pkg::CMD_LMR;
        nxt_addr = '0;
        nxt_ba   = '0;
        tld      = 1'b1;
        tval     = cyc(sdq_pkg::TMRD_CYC - 1);
        nxt_st   = sdq_pkg::SDQ_LMR_WAIT;
      end
      sdq_pkg::SDQ_LMR_WAIT: begin
        if (tif.done) begin
          nxt_st = sdq_pkg::SDQ_IDLE;
        end
      end
      sdq_pkg::SDQ_IDLE: begin
        if (overrun_ff) begin
          nxt_st   = sdq_pkg::SDQ_INIT_REF;
          nxt_refs = '0;
        end else if (ref_due_ff && cke_ff) begin
          nxt_st = sdq_pkg::SDQ_REF;
        end else if (accept) begin
          nxt_ba   = req_bank;
          nxt_addr = req_addr;
          unique case (req_op)
            sdq_pkg::OP_ACT:   nxt_cmd = sdq_pkg::CMD_ACT;
            sdq_pkg::OP_WRITE: begin
              nxt_cmd     = sdq_pkg::CMD_WRITE;
              nxt_addr[10] = req_auto_pre;
            end
            sdq_pkg::OP_READ:  begin
              nxt_cmd     = sdq_pkg::CMD_READ;
              nxt_addr[10] = req_auto_pre;
            end
            sdq_pkg::OP_PRE:   begin
              // Single bank only; all-bank would skip the other banks' timers
              nxt_cmd      = sdq_pkg::CMD_PRE;
              nxt_addr[10] = 1'b0;
            end
          endcase
        end
      end
      sdq_pkg::SDQ_REF: begin
        nxt_cmd = sdq_pkg::CMD_REF;
        tld     = 1'b1;
        tval    = cyc(sdq_pkg::TRFC_CYC - 1);
        nxt_st  = sdq_pkg::SDQ_REF_WAIT;
      end
      sdq_pkg::SDQ_REF_WAIT: begin
        if (tif.done) begin
          nxt_st = sdq_pkg::SDQ_IDLE;
        end
      end
      sdq_pkg::SDQ_HOLD: begin
        nxt_st = sdq_pkg::SDQ_IDLE;
      end
    endcase
  end

  // Per-bank row-active and write-recovery countdowns
  always_ff @(posedge clk) begin
    for (int b = 0; b < sdq_pkg::BANKS; b++) begin
      if (sys_rst) begin
        ras_ff[b] <= '0;
        wr_ff[b]  <= '0;
      end else if (accept && req_bank == 2'(b) && sel_act) begin
        ras_ff[b] <= 4'(sdq_pkg::TRAS_CYC);
      end else if (accept && req_bank == 2'(b) && sel_wr) begin
        // auto precharge still keeps at least one clock
        wr_ff[b]  <= 4'(sdq_pkg::TWR_CYC);
      end else begin
        if (ras_ff[b] != '0) ras_ff[b] <= ras_ff[b] - 4'h1;
        if (wr_ff[b] != '0)  wr_ff[b]  <= wr_ff[b] - 4'h1;
      end
    end
  end

  // Refresh interval tracker, running even in power-down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refcnt_ff  <= '0;
      ref_due_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      // Reload on tick too, so overrun needs a second full interval
      if (!init_ff || nxt_cmd == sdq_pkg::CMD_REF || ref_tick) begin
        refcnt_ff <= cyc(TREF_CYCLES - 1);
      end else if (!ref_tick) begin
        refcnt_ff <= refcnt_ff - 1'b1;
      end
      // Clear wins over set
      if (init_ff && ref_tick && nxt_cmd != sdq_pkg::CMD_REF) begin
        ref_due_ff <= 1'b1;
        overrun_ff <= ref_due_ff;
      end else if (nxt_cmd == sdq_pkg::CMD_REF) begin
        ref_due_ff <= 1'b0;
        overrun_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff   <= sdq_pkg::SDQ_PWRUP;
      refs_ff <= '0;
      cmd_ff  <= sdq_pkg::CMD_INHIBIT;
      ba_ff   <= '0;
      addr_ff <= '0;
    end else begin
      st_ff   <= nxt_st;
      refs_ff <= nxt_refs;
      cmd_ff  <= nxt_cmd;
      ba_ff   <= nxt_ba;
      addr_ff <= nxt_addr;
    end
  end

  // Power-up timer load on reset release; shares the state timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_ld_ff <= 1'b1;
      init_ff   <= 1'b0;
      cke_ff    <= 1'b1;
      ready_ff  <= 1'b0;
    end else begin
      pwr_ld_ff <= 1'b0;
      if (st_ff == sdq_pkg::SDQ_LMR_WAIT && tif.done) init_ff <= 1'b1;
      // Power-down only while idle; refresh due wakes it
      cke_ff   <= !(init_ff && in_idle && pd_req && !ref_due_ff && !accept);
      ready_ff <= (nxt_st == sdq_pkg::SDQ_IDLE) && init_ff && !ref_due_ff;
    end
  end

  assign req_ready     = ready_ff;
  assign init_done     = init_ff;
  assign clk_change_ok = ~cke_ff;
  assign mem_cke       = cke_ff;
  assign mem_cs_n      = cmd_ff[3];
  assign mem_ras_n     = cmd_ff[2];
  assign mem_cas_n     = cmd_ff[1];
  assign mem_we_n      = cmd_ff[0];
  assign mem_ba        = ba_ff;
  assign mem_addr      = addr_ff;
endmodule

// ---- src/sdq_timer.sv ----
// Loadable down counter that flags expiry
`timescale 1ns/1ns
module sdq_timer (
  input  wire logic clk,
  input  wire logic sys_rst,
  sdq_tmr_if.tmr    tif
);
  logic [sdq_pkg::CNT_W-1:0] cnt_ff;
  logic [sdq_pkg::CNT_W-1:0] nxt_cnt;
  wire                       at_zero = (cnt_ff == '0);

  assign nxt_cnt  = tif.load ? tif.value : (at_zero ? cnt_ff : cnt_ff - 1'b1);
  assign tif.done = at_zero && !tif.load;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// ---- test/sdq_ctrl_assertions.sv ----
// Port checks of the SDRAM command sequencer
`timescale 1ns/1ns
module sdq_ctrl_assertions #(
  parameter int unsigned PWRUP_CYCLES = 20,
  parameter int unsigned TREF_CYCLES  = 200,
  parameter int unsigned ADDR_W       = 13
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              req_valid,
  input wire logic [1:0]        req_op,
  input wire logic [1:0]        req_bank,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic              req_auto_pre,
  input wire logic              pd_req,
  input wire logic              req_ready,
  input wire logic              init_done,
  input wire logic              clk_change_ok,
  input wire logic              mem_cke,
  input wire logic              mem_cs_n,
  input wire logic              mem_ras_n,
  input wire logic              mem_cas_n,
  input wire logic              mem_we_n,
  input wire logic [1:0]        mem_ba,
  input wire logic [ADDR_W-1:0] mem_addr
);
  wire logic [3:0] cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  wire logic       quiet = mem_cs_n || cmd == sdq_pkg::CMD_NOP;
  wire logic       is_ref = cmd == sdq_pkg::CMD_REF;
  logic [15:0]     up_ff;
  logic [15:0]     gap_ff;
  logic [2:0]      refs_ff;
  // Uptime saturating, so long runs never wrap back into the pause window
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      up_ff   <= 16'h0000;
      gap_ff  <= 16'h0000;
      refs_ff <= 3'h0;
    end else begin
      up_ff   <= (&up_ff) ? up_ff : up_ff + 16'h0001;
      gap_ff  <= is_ref ? 16'h0000 : gap_ff + 16'h0001;
      refs_ff <= (is_ref && refs_ff != 3'h7) ? refs_ff + 3'h1 : refs_ff;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_quiet2;
    quiet [*2];
  endsequence
  a_pause_first: assert property (!mem_cs_n |-> up_ff >= PWRUP_CYCLES - 1)
    else $error("command during power-up pause");
  a_ready_init: assert property (req_ready |-> init_done)
    else $error("ready before initialization");
  a_init_refs: assert property ($rose(init_done) |-> refs_ff >= 3'h2)
    else $error("init done with too few refreshes");
  a_ref_quiet: assert property (is_ref |=> s_quiet2)
    else $error("command inside refresh cycle time");
  a_lmr_gap: assert property (cmd == sdq_pkg::CMD_LMR |=> quiet)
    else $error("no idle cycle after mode load");
  a_ras_gap: assert property (cmd == sdq_pkg::CMD_ACT |=>
    !(cmd == sdq_pkg::CMD_PRE && mem_ba == $past(mem_ba))) else $error("precharge too early");
  a_clk_change: assert property (clk_change_ok |-> !mem_cke)
    else $error("clock change allowed while clocked");
  a_clk_quiet: assert property (clk_change_ok |-> quiet && init_done)
    else $error("command while clock may change");
  a_wr_pre: assert property (cmd == sdq_pkg::CMD_WRITE |=>
    !(cmd == sdq_pkg::CMD_PRE && mem_ba == $past(mem_ba))) else $error("precharge in recovery");
  a_ref_gap: assert property (init_done |-> gap_ff <= TREF_CYCLES + 16)
    else $error("refresh interval overrun");
endmodule

bind sdq_ctrl sdq_ctrl_assertions #(
  .PWRUP_CYCLES(PWRUP_CYCLES), .TREF_CYCLES(TREF_CYCLES), .ADDR_W(ADDR_W)
) i_sdq_ctrl_assertions (.clk, .sys_rst, .req_valid, .req_op, .req_bank, .req_addr,
  .req_auto_pre, .pd_req, .req_ready, .init_done, .clk_change_ok, .mem_cke, .mem_cs_n,
  .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_ba, .mem_addr);

// ---- test/sdq_mem_model.sv ----
// Behavioural four-bank memory device
`timescale 1ns/1ns
module sdq_mem_model (
  input wire logic       clk,
  input wire logic       cke,
  input wire logic [3:0] cmd,
  input wire logic [1:0] ba,
  input wire logic       a10,
  output logic [7:0]     ref_cnt,
  output logic           bad
);
  logic [3:0] open_q = 4'h0;
  logic [3:0] apc_q = 4'h0;
  logic [1:0] busy_q = 2'h0;
  wire logic  nop = cmd[3] || cmd == sdq_pkg::CMD_NOP;
  initial begin
    ref_cnt = 8'h00;
    bad = 1'b0;
  end
  // Commands ignored while powered down
  always @(posedge clk) if (cke) begin
    open_q <= open_q & ~apc_q;
    apc_q <= 4'h0;
    if (busy_q != 2'h0) busy_q <= busy_q - 2'h1;
    if (busy_q != 2'h0 && !nop) bad <= 1'b1;
    case (cmd)
      sdq_pkg::CMD_REF: begin
        ref_cnt <= ref_cnt + 8'h01;
        busy_q <= 2'(sdq_pkg::TRFC_CYC - 1);
      end
      sdq_pkg::CMD_ACT: begin
        if (open_q[ba]) bad <= 1'b1;
        open_q[ba] <= 1'b1;
      end
      sdq_pkg::CMD_PRE: if (a10) open_q <= 4'h0; else open_q[ba] <= 1'b0;
      sdq_pkg::CMD_WRITE, sdq_pkg::CMD_READ: begin
        if (!open_q[ba]) bad <= 1'b1;
        if (a10) apc_q[ba] <= 1'b1;
      end
      default: ;
    endcase
  end
endmodule

// ---- test/tb_sdq_ctrl.sv ----
// Self-checking bench for the SDRAM command sequencer
`timescale 1ns/1ns
module tb_sdq_ctrl;
  localparam int unsigned PWR = 20;
  localparam int unsigned TRF = 200;
  logic        clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_auto_pre = 1'b0, pd_req = 1'b0;
  logic [1:0]  req_op = 2'h0, req_bank = 2'h0, mem_ba;
  logic [12:0] req_addr = 13'h0000, mem_addr;
  logic        req_ready, init_done, clk_change_ok, mem_cke, bad;
  logic        mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
  logic [7:0]  ref_cnt, mon_refs = 8'h00;
  logic [15:0] rnd = 16'h0015;
  logic [6:0]  exp_q [$];
  int          miscompares = 0, checks_done = 0;
  wire logic [3:0] cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  sdq_ctrl #(.PWRUP_CYCLES(PWR), .TREF_CYCLES(TRF)) i_sdq_ctrl (.clk, .sys_rst, .req_valid,
    .req_op, .req_bank, .req_addr, .req_auto_pre, .pd_req, .req_ready, .init_done,
    .clk_change_ok, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_ba, .mem_addr);
  sdq_mem_model i_sdq_mem_model (.clk, .cke(mem_cke), .cmd, .ba(mem_ba), .a10(mem_addr[10]),
    .ref_cnt, .bad);
  initial forever #20 clk = ~clk;
  function automatic void rnd_step();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
  endfunction
  function automatic logic [3:0] code_of(input logic [1:0] op);
    case (op)
      sdq_pkg::OP_ACT:   return sdq_pkg::CMD_ACT;
      sdq_pkg::OP_WRITE: return sdq_pkg::CMD_WRITE;
      sdq_pkg::OP_PRE:   return sdq_pkg::CMD_PRE;
      default:           return sdq_pkg::CMD_READ;
    endcase
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Held until the command shows, since a refused request is dropped silently
  task automatic do_op(input logic [1:0] op, input int b, input logic ap);
    int n;
    for (n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge clk);
    rnd_step();
    {req_valid, req_op, req_bank, req_addr, req_auto_pre} = {1'b1, op, 2'(b), rnd[12:0], ap};
    exp_q.push_back({code_of(op), 2'(b), op[0] & ap});
    for (n = 0; n < 400 && cmd !== code_of(op); n++) @(negedge clk);
    req_valid = 1'b0;
    @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (cmd == sdq_pkg::CMD_REF) mon_refs++;
    if (cmd inside {sdq_pkg::CMD_ACT, sdq_pkg::CMD_WRITE, sdq_pkg::CMD_PRE, sdq_pkg::CMD_READ})
      check({1'b0, cmd, mem_ba, !cmd[1] & mem_addr[10]}, {1'b0, exp_q.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    int n;
    logic [7:0] r0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    for (n = 0; n < 400 && init_done !== 1'b1; n++) @(negedge clk);
    check(8'(n >= PWR), 8'h01);
    check(8'(ref_cnt >= 8'h02), 8'h01);
    $display("test init finished");
    for (int b = 0; b < 4; b++) begin
      do_op(sdq_pkg::OP_ACT, b, 1'b0);
      do_op(sdq_pkg::OP_PRE, b, 1'b0);
      do_op(sdq_pkg::OP_ACT, b, 1'b0);
      do_op(sdq_pkg::OP_WRITE, b, rnd[1]);
      if (!req_auto_pre) do_op(sdq_pkg::OP_PRE, b, 1'b0);
      repeat (3) @(negedge clk);
      do_op(sdq_pkg::OP_ACT, b, 1'b0);
      do_op(sdq_pkg::OP_READ, b, 1'b1);
      repeat (3) @(negedge clk);
    end
    $display("test bank traffic finished");
    pd_req = 1'b1;
    for (n = 0; n < 400 && mem_cke !== 1'b0; n++) @(negedge clk);
    r0 = ref_cnt;
    repeat (2) @(negedge clk);
    check(8'(clk_change_ok), 8'h01);
    repeat (2 * TRF + 40) @(negedge clk);
    check(8'(ref_cnt > r0), 8'h01);
    pd_req = 1'b0;
    for (n = 0; n < 400 && mem_cke !== 1'b1; n++) @(negedge clk);
    repeat (2) @(negedge clk);
    check(8'(clk_change_ok), 8'h00);
    $display("test power-down finished");
    repeat (TRF) @(negedge clk);
    check(ref_cnt, mon_refs);
    check(8'(bad), 8'h00);
    check(8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule
